// file: isz_pkg.sv
// package: constants and carrier types for the increment-skip-on-zero unit
package isz_pkg;
  // ---------------------------------------------------------------
  // opcode layout
  // ---------------------------------------------------------------
  localparam logic [5:0] ISZ_OPCODE = 6'h0F; // top six bits 0011 11
  localparam int ISZ_OP_MSB = 15;
  localparam int ISZ_OP_LSB = 10;
  localparam int ISZ_DEST_BIT = 9;
  localparam int ISZ_BANK_BIT = 8;
  localparam logic [7:0] ISZ_INDEX_LIMIT = 8'h5F; // indexed when addr <= this
  localparam logic [7:0] ISZ_ACCESS_SPLIT = 8'h60; // access bank upper part starts here
  localparam logic [7:0] ISZ_ACCESS_HI_BANK = 8'h3F; // sfr bank of access
  // ---------------------------------------------------------------
  // register offsets (axi4-lite byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ISZ_REG_CTRL = 8'h00; // bit0 extended set enable
  localparam logic [7:0] ISZ_REG_INSTR = 8'h04; // write issues an instruction
  localparam logic [7:0] ISZ_REG_BANK = 8'h08; // bank selection register
  localparam logic [7:0] ISZ_REG_INDEX = 8'h0C; // index base for offset mode
  localparam logic [7:0] ISZ_REG_NEXTW = 8'h10; // words of following instr
  localparam logic [7:0] ISZ_REG_WREG = 8'h14; // working accumulator
  localparam logic [7:0] ISZ_REG_STATUS = 8'h18; // busy, skip, last address
  localparam logic [7:0] ISZ_REG_DATA = 8'h1C; // window into file memory
  localparam logic [7:0] ISZ_REG_DADDR = 8'h20; // file memory address
  localparam logic [7:0] ISZ_REG_CYCLES = 8'h24; // cycles of last instruction
  // reset values and bus response codes
  localparam logic [7:0] ISZ_RST_BYTE = 8'h00;
  localparam logic [1:0] ISZ_RST_NEXTW = 2'h1;
  localparam logic [1:0] ISZ_RESP_OKAY = 2'h0;
  localparam logic [1:0] ISZ_RESP_SLVERR = 2'h2;
  // phases of one instruction cycle and sequencer states
  typedef enum logic [1:0] {ISZ_Q1, ISZ_Q2, ISZ_Q3, ISZ_Q4} isz_phase_t;
  typedef enum {ISZ_IDLE, ISZ_EXEC, ISZ_FLUSH} isz_state_t;
  // decoded instruction
  typedef struct packed {
    logic dest; // 1: back to file register
    logic bank; // 1: bank selection register
    logic [7:0] addr;
  } isz_instr_t;
  // file memory port
  typedef struct packed {
    logic we;
    logic [11:0] addr;
    logic [7:0] wdata;
  } isz_mem_req_t;
endpackage

// file: isz_file_mem.sv
// file: data memory of the general purpose registers
`timescale 1ns/1ps
module isz_file_mem
  import isz_pkg::*;
(
  input wire logic aclk, // system clock
  input wire isz_mem_req_t req, // write enable, address, write data
  output logic [7:0] rdata // registered read data
);
  logic [7:0] mem [0:4095];

  // read-first memory; read data come out one cycle after the address
  always_ff @(posedge aclk) begin
    if (req.we) begin
      mem[req.addr] <= req.wdata;
    end
    rdata <= mem[req.addr];
  end
endmodule // isz_file_mem

// file: isz_core.sv
// file: increment-skip-on-zero execution unit with axi4-lite access
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
// Summary of operation
// [RULE_01] opcode 0011 11da ffff ffff increments the file register, no flags
// [RULE_02] dest bit 0 writes the accumulator, 1 writes back the register
// [RULE_03] zero result discards the fetched next instruction as no-operation
// [RULE_04] bank bit 0 uses the access bank, 1 uses bank selection register
// [RULE_05] indexed offset mode when bank 0, extended set on, address <= 5Fh
// [RULE_06] one word; 1 cycle, 2 on skip, 3 or 4 over longer instructions
// [RULE_07] phases decode, read, process, write; skipped words are four nops
// [RULE_08] increment wraps modulo 256, so FFh becomes zero and skips
module isz_core
  import isz_pkg::*;
(
  input wire logic aclk, // 50 MHz system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready // read data ready
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  isz_state_t state, next_state;
  isz_phase_t phase, next_phase;
  isz_instr_t instr, next_instr;
  logic [7:0] wreg, next_wreg;
  logic [7:0] bank_sel, next_bank_sel;
  logic [7:0] index_base, next_index_base;
  logic ext_en, next_ext_en;
  logic [1:0] next_words, next_next_words;
  logic [1:0] flush_left, next_flush_left;
  logic [2:0] cycles, next_cycles;
  logic skipped, next_skipped;
  logic [7:0] result, next_result;
  logic [11:0] eff_addr, next_eff_addr;
  logic [11:0] dbg_addr, next_dbg_addr;
  logic [7:0] mem_rdata;
  isz_mem_req_t mem_req;
  // bus state
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic ar_held, next_ar_held;
  logic [7:0] ar_addr, next_ar_addr;
  logic rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0] rresp, next_rresp;
  logic wr_go, rd_go, rd_wait, next_rd_wait;
  logic busy;
  // every check runs on aclk and sleeps through reset
  default clocking chk_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  isz_file_mem u_mem (
    .aclk(aclk),
    .req(mem_req),
    .rdata(mem_rdata)
  );

  // ---------------------------------------------------------------
  // axi4-lite slave
  // ---------------------------------------------------------------
  assign busy = (state != ISZ_IDLE);
  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready = !w_held && !bvalid;
  assign s_axi_arready = !ar_held && !rvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;
  // writes wait while an instruction runs so the memory port stays single
  assign wr_go = aw_held && w_held && !busy;
  // a data-window read needs the memory port, hence also waits for idle
  assign rd_go = ar_held && !rd_wait && !busy && !wr_go;

  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_ar_held = ar_held;
    next_ar_addr = ar_addr;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    next_rd_wait = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (wr_go) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = ISZ_RESP_OKAY;
      case (aw_addr)
        ISZ_REG_CTRL, ISZ_REG_INSTR, ISZ_REG_BANK, ISZ_REG_INDEX,
        ISZ_REG_NEXTW, ISZ_REG_WREG, ISZ_REG_DATA, ISZ_REG_DADDR: ;
        default: next_bresp = ISZ_RESP_SLVERR;
      endcase
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_ar_held = 1'b1;
      next_ar_addr = s_axi_araddr;
    end
    if (rd_go) begin
      next_rd_wait = 1'b1; // one cycle for registered memory data
    end
    if (rd_wait) begin
      next_ar_held = 1'b0;
      next_rvalid = 1'b1;
      next_rresp = ISZ_RESP_OKAY;
      next_rdata = 32'h0000_0000;
      case (ar_addr)
        ISZ_REG_CTRL: next_rdata[0] = ext_en;
        ISZ_REG_INSTR: next_rdata[9:0] = {instr.dest, instr.bank,
                                          instr.addr};
        ISZ_REG_BANK: next_rdata[7:0] = bank_sel;
        ISZ_REG_INDEX: next_rdata[7:0] = index_base;
        ISZ_REG_NEXTW: next_rdata[1:0] = next_words;
        ISZ_REG_WREG: next_rdata[7:0] = wreg;
        ISZ_REG_STATUS: next_rdata[21:0] = {eff_addr, result, skipped,
                                            busy};
        ISZ_REG_DATA: next_rdata[7:0] = mem_rdata;
        ISZ_REG_DADDR: next_rdata[11:0] = dbg_addr;
        ISZ_REG_CYCLES: next_rdata[2:0] = cycles;
        default: next_rresp = ISZ_RESP_SLVERR;
      endcase
    end
    if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // instruction sequencer
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_phase = phase;
    next_instr = instr;
    next_wreg = wreg;
    next_bank_sel = bank_sel;
    next_index_base = index_base;
    next_ext_en = ext_en;
    next_next_words = next_words;
    next_flush_left = flush_left;
    next_cycles = cycles;
    next_skipped = skipped;
    next_result = result;
    next_eff_addr = eff_addr;
    next_dbg_addr = dbg_addr;
    mem_req.we = 1'b0;
    mem_req.addr = eff_addr;
    mem_req.wdata = result;
    if (!busy && ar_held && !wr_go) begin
      mem_req.addr = dbg_addr;
    end
    // register writes; the low byte strobe gates every field, though instr and daddr fields reach into byte lane 1
    if (wr_go && w_strb[0]) begin
      case (aw_addr)
        ISZ_REG_CTRL: next_ext_en = w_data[0];
        ISZ_REG_BANK: next_bank_sel = w_data[7:0];
        ISZ_REG_INDEX: next_index_base = w_data[7:0];
        ISZ_REG_NEXTW: begin
          // zero words is meaningless; treated as one
          next_next_words = (w_data[1:0] == 2'h0) ? ISZ_RST_NEXTW
                                                  : w_data[1:0];
        end
        ISZ_REG_WREG: next_wreg = w_data[7:0];
        ISZ_REG_DADDR: next_dbg_addr = w_data[11:0];
        ISZ_REG_DATA: begin
          mem_req.we = 1'b1;
          mem_req.addr = dbg_addr;
          mem_req.wdata = w_data[7:0];
        end
        ISZ_REG_INSTR: begin
          // other opcodes are ignored here
          if (w_data[ISZ_OP_MSB:ISZ_OP_LSB] == ISZ_OPCODE) begin
            next_instr.dest = w_data[ISZ_DEST_BIT];
            next_instr.bank = w_data[ISZ_BANK_BIT];
            next_instr.addr = w_data[7:0];
            next_state = ISZ_EXEC; // see [RULE_01]
            next_phase = ISZ_Q1;
            next_skipped = 1'b0;
            next_cycles = 3'h0;
          end
        end
        default: ;
      endcase
    end
    case (state)
      ISZ_IDLE: ;
      ISZ_EXEC: begin
        next_phase = isz_phase_t'(phase + 2'h1);
        case (phase)
          ISZ_Q1: begin
            // decode: resolve the effective file address
            if (!instr.bank && ext_en && instr.addr <= ISZ_INDEX_LIMIT) begin
              next_eff_addr = {4'h0, index_base + instr.addr}; // see [RULE_05]
            end else if (instr.bank) begin
              next_eff_addr = {bank_sel[3:0], instr.addr}; // see [RULE_04]
            end else if (instr.addr >= ISZ_ACCESS_SPLIT) begin
              next_eff_addr = {ISZ_ACCESS_HI_BANK[3:0], instr.addr};
            end else begin
              next_eff_addr = {4'h0, instr.addr}; // see [RULE_04]
            end
          end
          ISZ_Q2: ; // read issued; data register loads at the q3 edge
          ISZ_Q3: next_result = mem_rdata + 8'h01; // see [RULE_08]
          ISZ_Q4: begin
            // write destination; no status flags touched, see [RULE_01]
            if (instr.dest) begin
              mem_req.we = 1'b1; // see [RULE_02]
            end else begin
              next_wreg = result; // see [RULE_02]
            end
            next_cycles = 3'h1;
            if (result == 8'h00) begin
              next_skipped = 1'b1; // see [RULE_03]
              next_flush_left = next_words; // see [RULE_06]
              next_state = ISZ_FLUSH;
            end else begin
              next_state = ISZ_IDLE;
            end
          end
          default: ;
        endcase
      end
      ISZ_FLUSH: begin
        // each skipped word is one cycle of four idle phases, see [RULE_07]
        next_phase = isz_phase_t'(phase + 2'h1);
        if (phase == ISZ_Q4) begin
          next_cycles = cycles + 3'h1;
          next_flush_left = flush_left - 2'h1;
          if (flush_left == 2'h1) begin
            next_state = ISZ_IDLE;
          end
        end
      end
      default: next_state = ISZ_IDLE;
    endcase
  end

  // register all state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ISZ_IDLE;
      phase <= ISZ_Q1;
      instr <= '0;
      wreg <= ISZ_RST_BYTE;
      bank_sel <= ISZ_RST_BYTE;
      index_base <= ISZ_RST_BYTE;
      ext_en <= 1'b0;
      next_words <= ISZ_RST_NEXTW;
      flush_left <= 2'h0;
      cycles <= 3'h0;
      skipped <= 1'b0;
      result <= ISZ_RST_BYTE;
      eff_addr <= 12'h000;
      dbg_addr <= 12'h000;
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= ISZ_RESP_OKAY;
      ar_held <= 1'b0;
      ar_addr <= 8'h00;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= ISZ_RESP_OKAY;
      rd_wait <= 1'b0;
    end else begin
      state <= next_state;
      phase <= next_phase;
      instr <= next_instr;
      wreg <= next_wreg;
      bank_sel <= next_bank_sel;
      index_base <= next_index_base;
      ext_en <= next_ext_en;
      next_words <= next_next_words;
      flush_left <= next_flush_left;
      cycles <= next_cycles;
      skipped <= next_skipped;
      result <= next_result;
      eff_addr <= next_eff_addr;
      dbg_addr <= next_dbg_addr;
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      ar_held <= next_ar_held;
      ar_addr <= next_ar_addr;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      rd_wait <= next_rd_wait;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_result_wraps: assert property ( // see [RULE_08]
    (state == ISZ_EXEC && phase == ISZ_Q3)
    |=> result == $past(mem_rdata) + 8'h01)
    else $error("result is not operand plus one");
  chk_zero_skips: assert property ( // see [RULE_03]
    (state == ISZ_EXEC && phase == ISZ_Q4 && result == 8'h00)
    |=> state == ISZ_FLUSH && skipped)
    else $error("zero result did not skip");
  chk_nonzero_idle: assert property ( // see [RULE_03]
    (state == ISZ_EXEC && phase == ISZ_Q4 && result != 8'h00)
    |=> state == ISZ_IDLE && !skipped)
    else $error("nonzero result skipped");
  chk_wreg_dest: assert property ( // see [RULE_02]
    (state == ISZ_EXEC && phase == ISZ_Q4 && !instr.dest)
    |=> wreg == $past(result))
    else $error("accumulator not written");
  chk_file_dest: assert property ( // see [RULE_02]
    (state == ISZ_EXEC && phase == ISZ_Q4) |-> mem_req.we == instr.dest)
    else $error("file write does not follow dest bit");
  chk_exec_length: assert property ( // see [RULE_07]
    (state == ISZ_EXEC && phase == ISZ_Q1) |-> (state == ISZ_EXEC) [*4])
    else $error("execute cycle not four phases");
  chk_flush_cycles: assert property ( // see [RULE_06]
    ($fell(busy) && skipped) |-> cycles == {1'b0, next_words} + 3'h1)
    else $error("skip cycle count wrong");
  chk_index_mode: assert property ( // see [RULE_05]
    (state == ISZ_EXEC && phase == ISZ_Q1 && !instr.bank && ext_en
     && instr.addr <= ISZ_INDEX_LIMIT)
    |=> eff_addr == {4'h0, $past(index_base) + $past(instr.addr)})
    else $error("indexed address wrong");
  chk_bank_mode: assert property ( // see [RULE_04]
    (state == ISZ_EXEC && phase == ISZ_Q1 && instr.bank)
    |=> eff_addr == {$past(bank_sel[3:0]), $past(instr.addr)})
    else $error("banked address wrong");
endmodule // isz_core

// file: isz_tb.sv
// testbench: random increment-skip-on-zero runs against a bench model
`timescale 1ns/1ps
module testbench
  import isz_pkg::*;
;
  // ---------------------------------------------------------------
  // signals and bench state
  // ---------------------------------------------------------------
  logic aclk, aresetn;
  logic [7:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int n_errors = 0;
  int checked = 0;
  logic [31:0] seed = 32'h0000_D754; // 55124, the agreed start value
  byte unsigned mem_m [int]; // model of file memory, by effective address

  isz_core uut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready)
  );

  // free running 50 MHz clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic end_of_test();
    $display("counts: checked %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask

  // handshakes are judged just before the edge, released right after it
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic awh, wh, bh;
    logic [1:0] r;
    int t;
    awh = 0; wh = 0; bh = 0; r = 2'h3; t = 0;
    @(posedge aclk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bh && t < 200) begin
      @(negedge aclk);
      awh = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid && bready;
      if (bh) r = bresp;
      @(posedge aclk);
      if (awh) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (bh) bready <= 1'b0;
      t++;
    end
    chk("bvalid seen", 32'h0000_0001, {31'h0, bh});
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er,
                    output logic [31:0] d);
    logic arh, rh;
    int t;
    arh = 0; rh = 0; t = 0; d = 32'hFFFF_FFFF;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (!rh && t < 200) begin
      @(negedge aclk);
      arh = arvalid && arready;
      rh = rvalid && rready;
      if (rh) d = rdata;
      if (rh) chk("rresp", {30'h0, er}, {30'h0, rresp});
      @(posedge aclk);
      if (arh) arvalid <= 1'b0;
      if (rh) rready <= 1'b0;
      t++;
    end
    chk("rvalid seen", 32'h0000_0001, {31'h0, rh});
  endtask

  // model of effective address: bank register, indexed, or access bank
  function automatic logic [11:0] eff(input logic bnk, input logic ext,
      input logic [7:0] f, input logic [3:0] bk, input logic [7:0] idx);
    logic [7:0] s;
    s = idx + f;
    if (bnk) return {bk, f};
    if (ext && f <= ISZ_INDEX_LIMIT) return {4'h0, s};
    if (f < ISZ_ACCESS_SPLIT) return {4'h0, f};
    return {4'hF, f};
  endfunction

  // watchdog: the whole sequence needs well under 60000 cycles
  initial begin
    #(20 * 60000);
    n_errors++;
    $display("mismatch watchdog expected done seen timeout");
    end_of_test();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] r, d, w0, st;
    logic [7:0] f, val, res, idx;
    logic [3:0] bk;
    logic [11:0] ea;
    logic dest, bnk, ext, skip;
    int nw, p;
    aresetn = 1'b0; awaddr = 8'h00; awvalid = 1'b0; wdata = 32'h0;
    wstrb = 4'hF; wvalid = 1'b0; bready = 1'b0; araddr = 8'h00;
    arvalid = 1'b0; rready = 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values and refused addresses
    rd(ISZ_REG_CTRL, ISZ_RESP_OKAY, d);
    chk("ctrl reset", 32'h0, d);
    rd(ISZ_REG_NEXTW, ISZ_RESP_OKAY, d);
    chk("nextw reset", 32'h1, d);
    rd(8'h40, ISZ_RESP_SLVERR, d);
    chk("unmapped rdata", 32'h0, d);
    wr(8'h40, 32'h5, ISZ_RESP_SLVERR);
    wr(ISZ_REG_NEXTW, 32'h0, ISZ_RESP_OKAY);
    rd(ISZ_REG_NEXTW, ISZ_RESP_OKAY, d);
    chk("nextw zero", 32'h1, d);
    // a neighbouring opcode must leave state alone
    wr(ISZ_REG_DADDR, 32'h010, ISZ_RESP_OKAY);
    wr(ISZ_REG_DATA, 32'h7, ISZ_RESP_OKAY);
    wr(ISZ_REG_WREG, 32'h3, ISZ_RESP_OKAY);
    wr(ISZ_REG_INSTR, 32'h2A10, ISZ_RESP_OKAY);
    repeat (20) @(posedge aclk);
    rd(ISZ_REG_DATA, ISZ_RESP_OKAY, d);
    chk("other opcode mem", 32'h7, d);
    rd(ISZ_REG_WREG, ISZ_RESP_OKAY, d);
    chk("other opcode wreg", 32'h3, d);
    $display("test reset and decode done");
    // random instructions, boundary addresses and forced wraps
    for (int i = 0; i < 30; i++) begin
      r = rnd();
      f = r[7:0]; dest = r[8]; bnk = r[9]; ext = r[10];
      nw = (r[12:11] == 2'h0) ? 1 : int'(r[12:11]);
      bk = r[19:16]; idx = r[27:20]; val = r[31:24];
      if (i % 6 == 1) f = ISZ_INDEX_LIMIT;
      if (i % 6 == 2) f = ISZ_ACCESS_SPLIT;
      if (i % 3 == 0) val = 8'hFF;
      w0 = rnd() & 32'h0000_00FF;
      ea = eff(bnk, ext, f, bk, idx);
      mem_m[ea] = val;
      wr(ISZ_REG_CTRL, {31'h0, ext}, ISZ_RESP_OKAY);
      wr(ISZ_REG_BANK, {28'h0, bk}, ISZ_RESP_OKAY);
      wr(ISZ_REG_INDEX, {24'h0, idx}, ISZ_RESP_OKAY);
      wr(ISZ_REG_NEXTW, nw, ISZ_RESP_OKAY);
      wr(ISZ_REG_WREG, w0, ISZ_RESP_OKAY);
      wr(ISZ_REG_DADDR, {20'h0, ea}, ISZ_RESP_OKAY);
      wr(ISZ_REG_DATA, {24'h0, val}, ISZ_RESP_OKAY);
      wr(ISZ_REG_INSTR, {16'h0, ISZ_OPCODE, dest, bnk, f}, ISZ_RESP_OKAY);
      p = 0;
      st = 32'h1;
      while (st[0] !== 1'b0 && p < 50) begin
        rd(ISZ_REG_STATUS, ISZ_RESP_OKAY, st);
        p++;
      end
      res = val + 8'h01;
      skip = (res == 8'h00);
      if (!dest) mem_m[ea] = val;
      if (dest) mem_m[ea] = res;
      chk("busy", 32'h0, {31'h0, st[0]});
      chk("eff addr", 32'(ea), 32'(st[21:10]));
      chk("result", 32'(res), 32'(st[9:2]));
      chk("skipped", {31'h0, skip}, {31'h0, st[1]});
      rd(ISZ_REG_CYCLES, ISZ_RESP_OKAY, d);
      chk("cycles", skip ? 1 + nw : 1, d);
      rd(ISZ_REG_WREG, ISZ_RESP_OKAY, d);
      chk("wreg", dest ? w0 : {24'h0, res}, d);
      rd(ISZ_REG_DATA, ISZ_RESP_OKAY, d);
      chk("file reg", {24'h0, mem_m[ea]}, d);
      rd(ISZ_REG_INSTR, ISZ_RESP_OKAY, d);
      chk("instr", {22'h0, dest, bnk, f}, d);
      $display("test instr %0d done f=%h skip=%0d", i, f, skip);
    end
    end_of_test();
  end
endmodule // testbench
